// ===== hdl/adcsq_top.sv
// converter sequencer: registers, pin configuration and sar timing
// assumes an external comparator and dac driven by dac_code_q,
// and a cpu-side interrupt controller reading the done flag outputs
// and register strobes that are one cycle long and never both high
`timescale 1ns/1ns
`default_nettype none
module adcsq_top
    import adcsq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata_q,
    input  wire logic        internal_rc_clock,
    input  wire logic        comp_above,
    output logic             converter_power_on_q,
    output logic      [3:0]  channel_select_q,
    output logic             reference_select_q,
    output logic      [15:0] analog_pins_q,
    output logic             sample_connect_q,
    output logic      [9:0]  dac_code_q,
    output logic             conversion_go_flag_q,
    output logic             conv_done_flag_q,
    output logic             conv_done_irq_enable_q
);

    // ==================================================
    // declarations
    adcsq_clksel_t clk_sel_q;
    adcsq_state_t  state_q;
    logic          result_justify_q;
    logic [2:0]    pin_config_select_q;
    logic [9:0]    result_q;
    logic [9:0]    bit_q;
    logic [3:0]    tad_cnt_q;
    logic [1:0]    pins_sync;
    logic          rc_sync;
    logic          comp_sync;
    logic          tad_tick;
    logic          run;
    logic          done_evt;
    logic          last_conv_tad;
    logic          last_recov_tad;
    logic          in_acq;
    logic          go_wr;
    logic          power_drop;
    logic          wr_ctrl;
    logic          wr_cfg;
    logic          wr_stat;
    logic [7:0]    ctrl_rd;
    logic [7:0]    cfg_rd;
    logic [7:0]    stat_rd;
    logic [7:0]    res_high_rd;
    logic [7:0]    res_low_rd;
    logic [7:0]    read_mux;
    logic [15:0]   analog_d;

    // ==================================================
    // pin synchronisers
    adcsq_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({internal_rc_clock, comp_above}),
        .sync_q   (pins_sync)
    );

    assign rc_sync   = pins_sync[1];
    assign comp_sync = pins_sync[0];

    // ==================================================
    // conversion period ticks
    assign in_acq = (state_q == ST_ACQ);
    assign run    = !in_acq;

    adcsq_tad_gen u_tad (
        .clk     (clk),
        .rst     (rst),
        .run     (run),
        .clk_sel (clk_sel_q),
        .rc_sync (rc_sync),
        .tick_q  (tad_tick)
    );

    // ==================================================
    // write decode
    assign wr_ctrl = wr && (addr == ADDR_CTRL_MAIN);
    assign wr_cfg  = wr && (addr == ADDR_CONFIG);
    assign wr_stat = wr && (addr == ADDR_STATUS);
    assign go_wr   = wr_ctrl && wdata[CTRL_GO_BIT];
    // power-off write drops go on its own edge, so go never outlives power
    assign power_drop = wr_ctrl && !wdata[CTRL_POWER_BIT];

    // ==================================================
    // main control register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            converter_power_on_q <= RESET_BIT;
            channel_select_q     <= RESET_CHAN;
        end else if (wr_ctrl) begin
            converter_power_on_q <= wdata[CTRL_POWER_BIT];
            channel_select_q     <= wdata[CTRL_CHAN_LSB +: 4];
        end
    end

    // go accepted only if power was already on before this write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conversion_go_flag_q <= RESET_BIT;
        end else if (done_evt || !converter_power_on_q || power_drop) begin
            conversion_go_flag_q <= 1'b0;
        end else if (go_wr) begin
            conversion_go_flag_q <= 1'b1;
        end
    end

    // ==================================================
    // configuration register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_sel_q           <= CLK_DIV8;
            result_justify_q    <= RESET_BIT;
            pin_config_select_q <= RESET_PCFG;
            reference_select_q  <= RESET_BIT;
        end else if (wr_cfg) begin
            clk_sel_q           <= adcsq_clksel_t'(wdata[CFG_CLKSEL_LSB +: 2]);
            result_justify_q    <= wdata[CFG_JUSTIFY_BIT];
            pin_config_select_q <= wdata[CFG_PCFG_LSB +: 3];
            reference_select_q  <= wdata[CFG_REF_BIT];
        end
    end

    // ==================================================
    // done flag and its enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_done_flag_q <= RESET_BIT;
        end else if (done_evt) begin
            conv_done_flag_q <= 1'b1;
        end else if (wr_stat) begin
            conv_done_flag_q <= wdata[STAT_DONE_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_done_irq_enable_q <= RESET_BIT;
        end else if (wr_stat) begin
            conv_done_irq_enable_q <= wdata[STAT_IE_BIT];
        end
    end

    // ==================================================
    // analog pin map, digital pins taken from the top of each group
    always_comb begin
        analog_d = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            if (pin_config_select_q != PCFG_ALL_D
                && 4'(i) + {1'b0, pin_config_select_q} < GROUP_PINS) begin
                analog_d[i]     = 1'b1;
                analog_d[i + 8] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_pins_q <= RESET_ANALOG;
        end else begin
            analog_pins_q <= analog_d;
        end
    end

    // ==================================================
    // sequencer: acquire, convert twelve periods, recover two periods
    assign last_conv_tad  = (tad_cnt_q == CONV_TADS - 4'h1);
    assign last_recov_tad = (tad_cnt_q == RECOV_TADS - 4'h1);
    assign done_evt = (state_q == ST_CONV) && tad_tick && last_conv_tad;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q   <= ST_ACQ;
            tad_cnt_q <= 4'h0;
        end else begin
            unique case (state_q)
                ST_ACQ: begin
                    // a go set during recovery waits here for acquire
                    tad_cnt_q <= 4'h0;
                    if (conversion_go_flag_q && converter_power_on_q) begin
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (!converter_power_on_q) begin
                        state_q   <= ST_ACQ;
                        tad_cnt_q <= 4'h0;
                    end else if (done_evt) begin
                        state_q   <= ST_RECOV;
                        tad_cnt_q <= 4'h0;
                    end else if (tad_tick) begin
                        tad_cnt_q <= tad_cnt_q + 4'h1;
                    end
                end
                ST_RECOV: begin
                    if (!converter_power_on_q) begin
                        state_q   <= ST_ACQ;
                        tad_cnt_q <= 4'h0;
                    end else if (tad_tick && last_recov_tad) begin
                        state_q   <= ST_ACQ;
                        tad_cnt_q <= 4'h0;
                    end else if (tad_tick) begin
                        tad_cnt_q <= tad_cnt_q + 4'h1;
                    end
                end
                default: begin
                    state_q   <= ST_ACQ;
                    tad_cnt_q <= 4'h0;
                end
            endcase
        end
    end

    // ==================================================
    // holding capacitor switch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_connect_q <= 1'b0;
        end else begin
            sample_connect_q <= converter_power_on_q && (state_q == ST_ACQ);
        end
    end

    // ==================================================
    // successive approximation, one bit per period from the second
    // the first period may be a partial rc cycle, so it decides no bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dac_code_q <= RESET_RESULT;
            bit_q      <= RESET_RESULT;
        end else if (state_q == ST_ACQ) begin
            dac_code_q <= SAR_MSB;
            bit_q      <= SAR_MSB;
        end else if (state_q == ST_CONV && tad_tick
                     && tad_cnt_q != 4'h0 && bit_q != RESET_RESULT) begin
            dac_code_q <= (comp_sync ? dac_code_q : (dac_code_q & ~bit_q))
                          | (bit_q >> 1);
            bit_q      <= bit_q >> 1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_q <= RESET_RESULT;
        end else if (done_evt) begin
            result_q <= dac_code_q;
        end
    end

    // ==================================================
    // read views
    // result views follow the justify bit live; the pair is not latched
    assign ctrl_rd = {channel_select_q, 1'b0, conversion_go_flag_q,
                      1'b0, converter_power_on_q};
    assign cfg_rd  = {clk_sel_q, result_justify_q, 1'b0,
                      pin_config_select_q, reference_select_q};
    assign stat_rd = {6'h00, conv_done_irq_enable_q, conv_done_flag_q};

    always_comb begin
        if (result_justify_q) begin
            res_high_rd = {6'h00, result_q[9:8]};
            res_low_rd  = result_q[7:0];
        end else begin
            res_high_rd = result_q[9:2];
            res_low_rd  = {result_q[1:0], 6'h00};
        end
    end

    always_comb begin
        unique case (addr)
            ADDR_CTRL_MAIN:   read_mux = ctrl_rd;
            ADDR_CONFIG:      read_mux = cfg_rd;
            ADDR_RESULT_HIGH: read_mux = res_high_rd;
            ADDR_RESULT_LOW:  read_mux = res_low_rd;
            ADDR_STATUS:      read_mux = stat_rd;
            default:          read_mux = 8'h00;
        endcase
    end

    // data valid only in the cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            rdata_q <= read_mux;
        end else begin
            rdata_q <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// ===== common/adcsq_pkg.sv
// constants, field layout and types of the converter sequencer
// assumes one 100 MHz system clock and an 8-bit register port
//
// Operation
// - power bit on runs the converter; off shuts it down
// - clock select 00, 01, 10 gives oscillator divided by 8, 32, 64
// - clock select 11 takes the period from the internal rc clock
// - justify set: result right justified, upper six high bits zero
// - justify clear: result left justified, lower six low bits zero
// - unimplemented control bits read back as zero
// - reference select 1 uses external reference pins, 0 supply rails
// - pin config turns pins digital downward from channels 15 and 7
// - full ten-bit result held across the high and low registers
// - completion loads result, clears go bit, sets done flag together
// - conversion takes twelve periods and starts on go bit set
// - holding capacitor stays on the channel during acquisition
// - channel select 0 to 15 picks analog input channel 0 to 15
// - writing go with power on starts; reads 1 until hardware clears
package adcsq_pkg;

    // ==================================================
    // register addresses
    localparam logic [7:0] ADDR_CTRL_MAIN   = 8'h14;
    localparam logic [7:0] ADDR_CONFIG      = 8'h15;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h16;
    localparam logic [7:0] ADDR_RESULT_LOW  = 8'h17;
    localparam logic [7:0] ADDR_STATUS      = 8'h18;

    // ==================================================
    // field positions
    localparam int CTRL_POWER_BIT  = 0;
    localparam int CTRL_GO_BIT     = 2;
    localparam int CTRL_CHAN_LSB   = 4;
    localparam int CFG_REF_BIT     = 0;
    localparam int CFG_PCFG_LSB    = 1;
    localparam int CFG_JUSTIFY_BIT = 5;
    localparam int CFG_CLKSEL_LSB  = 6;
    localparam int STAT_DONE_BIT   = 0;
    localparam int STAT_IE_BIT     = 1;

    // ==================================================
    // reset values
    localparam logic       RESET_BIT     = 1'b0;
    localparam logic [3:0] RESET_CHAN    = 4'h0;
    localparam logic [2:0] RESET_PCFG    = 3'h0;
    localparam logic [9:0] RESET_RESULT  = 10'h000;
    localparam logic [15:0] RESET_ANALOG = 16'h0000;

    // ==================================================
    // timing counts in system clocks and periods
    localparam logic [5:0] DIV8_LAST  = 6'h07;
    localparam logic [5:0] DIV32_LAST = 6'h1f;
    localparam logic [5:0] DIV64_LAST = 6'h3f;
    localparam logic [3:0] CONV_TADS  = 4'hc;
    localparam logic [3:0] RECOV_TADS = 4'h2;

    // ==================================================
    // converter geometry
    localparam logic [9:0] SAR_MSB     = 10'h200;
    localparam logic [2:0] PCFG_ALL_D  = 3'h7;
    localparam logic [3:0] GROUP_PINS  = 4'h8;

    typedef enum logic [1:0] {
        CLK_DIV8  = 2'h0,
        CLK_DIV32 = 2'h1,
        CLK_DIV64 = 2'h2,
        CLK_RC    = 2'h3
    } adcsq_clksel_t;

    typedef enum logic [2:0] {
        ST_ACQ   = 3'h1,
        ST_CONV  = 3'h2,
        ST_RECOV = 3'h4
    } adcsq_state_t;

endpackage

// ===== hdl/adcsq_sync.sv
// two-stage synchroniser for pin levels
// assumes inputs asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module adcsq_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/adcsq_tad_gen.sv
// conversion period tick from system clock divider or rc clock edges
// assumes rc_sync already passed a synchroniser
`timescale 1ns/1ns
`default_nettype none
module adcsq_tad_gen
    import adcsq_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     run,
    input  wire adcsq_pkg::adcsq_clksel_t clk_sel,
    input  wire logic                     rc_sync,
    output logic                          tick_q
);
    logic [5:0] div_cnt_q;
    logic [5:0] div_last;
    logic       rc_prev_q;

    always_comb begin
        unique case (clk_sel)
            CLK_DIV8:  div_last = DIV8_LAST;
            CLK_DIV32: div_last = DIV32_LAST;
            CLK_DIV64: div_last = DIV64_LAST;
            CLK_RC:    div_last = DIV64_LAST;
        endcase
    end

    // divider restarts with each run so the first period is whole
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_q <= 6'h00;
        end else if (!run || div_cnt_q == div_last) begin
            div_cnt_q <= 6'h00;
        end else begin
            div_cnt_q <= div_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rc_prev_q <= 1'b0;
        end else begin
            rc_prev_q <= rc_sync;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_q <= 1'b0;
        end else if (!run) begin
            tick_q <= 1'b0;
        end else if (clk_sel == CLK_RC) begin
            tick_q <= rc_sync && !rc_prev_q;
        end else begin
            tick_q <= (div_cnt_q == div_last);
        end
    end
endmodule
`default_nettype wire

// ===== verification/adcsq_top_assertions.sv
// port checker of the converter sequencer
// assumes binding to adcsq_top, single clock domain
`timescale 1ns/1ns
`default_nettype none
module adcsq_top_assertions (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata_q,
    input wire logic        converter_power_on_q,
    input wire logic        sample_connect_q,
    input wire logic [9:0]  dac_code_q,
    input wire logic        conversion_go_flag_q,
    input wire logic        conv_done_flag_q
);
    import adcsq_pkg::*;
    // ==========================================
    // go length counter
    logic [9:0] go_len_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            go_len_q <= 10'h000;
        end else if (!conversion_go_flag_q) begin
            go_len_q <= 10'h000;
        end else if (go_len_q != 10'h3ff) begin
            go_len_q <= go_len_q + 10'h001;
        end
    end
    // ==========================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    go_power_a: assert property (conversion_go_flag_q |-> converter_power_on_q)
        else $error("go flag high while powered off");
    off_disconn_a: assert property (!converter_power_on_q && !$past(converter_power_on_q)
        |-> !sample_connect_q) else $error("capacitor connected while powered off");
    go_start_a: assert property ($rose(conversion_go_flag_q) |-> $past(wr)
        && $past(addr) == ADDR_CTRL_MAIN && $past(wdata[2]) && $past(converter_power_on_q))
        else $error("go flag rose without a powered go write");
    done_event_a: assert property ($fell(conversion_go_flag_q) && converter_power_on_q
        |-> conv_done_flag_q) else $error("completion without done flag");
    done_sticky_a: assert property ($fell(conv_done_flag_q)
        |-> $past(wr) && $past(addr) == ADDR_STATUS) else $error("done flag dropped by itself");
    conv_len_a: assert property ($fell(conversion_go_flag_q) && converter_power_on_q
        |-> go_len_q >= 10'h060) else $error("conversion shorter than twelve periods");
    recov_gap_a: assert property ($fell(conversion_go_flag_q) && converter_power_on_q
        |-> !sample_connect_q [*8]) else $error("capacitor reconnected inside recovery");
    acq_msb_a: assert property ($rose(sample_connect_q) |-> dac_code_q == SAR_MSB)
        else $error("acquisition without midscale trial code");
    ctrl_unimpl_a: assert property ($past(rd) && $past(addr) == ADDR_CTRL_MAIN
        |-> rdata_q[3] == 1'b0 && rdata_q[1] == 1'b0) else $error("unimplemented bit read high");
    cover property ($fell(conversion_go_flag_q) && converter_power_on_q);
    cover property ($fell(conversion_go_flag_q) && !converter_power_on_q);
    cover property ($fell(conv_done_flag_q));
endmodule
`default_nettype wire

// ===== verification/adcsq_analog_model.sv
// far side: analog source with holding capacitor and rc oscillator
// assumes target level set by the bench, clk the system clock
`timescale 1ns/1ns
`default_nettype none
module adcsq_analog_model (
    input  wire logic       clk,
    input  wire logic [9:0] target,
    input  wire logic       sample_connect,
    input  wire logic [9:0] dac_code,
    output logic            comp_above,
    output logic            rc_clk
);
    logic [9:0] held_q = 10'h000;
    // capacitor follows the channel only while connected
    always @(posedge clk) begin
        if (sample_connect) begin
            held_q <= target;
        end
    end
    assign comp_above = (held_q >= dac_code);
    // free running rc oscillator, 16 system clocks a period
    initial begin
        rc_clk = 1'b0;
        forever #80 rc_clk = ~rc_clk;
    end
endmodule
`default_nettype wire

// ===== verification/tb_adcsq_top.sv
// register level bench of the converter sequencer
// assumes adcsq_top, the analog model and the checker
`timescale 1ns/1ns
`default_nettype none
module tb_adcsq_top;
    import adcsq_pkg::*;
    logic        clk, rst, wr, rd, internal_rc_clock, comp_above;
    logic        converter_power_on_q, reference_select_q, sample_connect_q;
    logic        conversion_go_flag_q, conv_done_flag_q, conv_done_irq_enable_q;
    logic [7:0]  addr, wdata, rdata_q, g;
    logic [3:0]  channel_select_q;
    logic [15:0] analog_pins_q;
    logic [9:0]  dac_code_q, target, tv;
    logic [7:0]  regs [6] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h20};
    logic [9:0]  tvs [4] = '{10'h2a5, 10'h15a, 10'h3ff, 10'h001};
    int          los [4] = '{96, 384, 768, 176};
    int          n_fail, n_checks, cyc;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    adcsq_top adcsq_top_i (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata_q, .internal_rc_clock,
        .comp_above, .converter_power_on_q, .channel_select_q, .reference_select_q,
        .analog_pins_q, .sample_connect_q, .dac_code_q, .conversion_go_flag_q,
        .conv_done_flag_q, .conv_done_irq_enable_q);
    adcsq_analog_model adcsq_analog_model_i (.clk, .target, .sample_connect(sample_connect_q),
        .dac_code(dac_code_q), .comp_above, .rc_clk(internal_rc_clock));
    // ==========================================
    // tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int v, input int lo, input int hi);
        n_checks++;
        if (v < lo || v > hi) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %0d cycles outside %0d..%0d", $time, v, lo, hi);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(16'(rdata_q), 16'(exp));
    endtask
    task automatic wait_go(output int c);
        c = 0;
        while (conversion_go_flag_q !== 1'b0 && c < 3000) begin
            @(posedge clk);
            #1 c++;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        finish_test();
    end
    // ==========================================
    // tests
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        target = 10'h000;
        n_fail = 0;
        n_checks = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        chk(analog_pins_q, 16'hffff);
        $display("test reset values done");
        wr_reg(ADDR_CONFIG, 8'hff);
        rd_chk(ADDR_CONFIG, 8'hef);
        chk(16'(reference_select_q), 16'h0001);
        wr_reg(ADDR_CTRL_MAIN, 8'hfe);
        rd_chk(ADDR_CTRL_MAIN, 8'hf0);
        chk(16'(channel_select_q), 16'h000f);
        wr_reg(ADDR_CTRL_MAIN, 8'h05);
        rd_chk(ADDR_CTRL_MAIN, 8'h01);
        wr_reg(8'h20, 8'hff);
        rd_chk(8'h20, 8'h00);
        $display("test access kinds done");
        for (int n = 0; n < 8; n++) begin
            wr_reg(ADDR_CONFIG, 8'(n << CFG_PCFG_LSB));
            @(posedge clk);
            g = (n == 7) ? 8'h00 : (8'hff >> n);
            #1 chk(analog_pins_q, {g, g});
        end
        chk(16'(reference_select_q), 16'h0000);
        $display("test pin configuration done");
        for (int k = 0; k < 4; k++) begin
            tv = tvs[k];
            target = tv;
            wr_reg(ADDR_CONFIG, {k[1:0], k[0], 5'h00});
            wr_reg(ADDR_CTRL_MAIN, 8'h31);
            wr_reg(ADDR_STATUS, 8'h02);
            repeat (150) @(posedge clk);
            wr_reg(ADDR_CTRL_MAIN, 8'h35);
            #1 chk(16'(conversion_go_flag_q), 16'h0001);
            wait_go(cyc);
            chk_rng(cyc, los[k], los[k] + los[k] / 4 + 24);
            chk(16'(conv_done_flag_q), 16'h0001);
            rd_chk(ADDR_CTRL_MAIN, 8'h31);
            rd_chk(ADDR_RESULT_HIGH, k[0] ? {6'h00, tv[9:8]} : tv[9:2]);
            rd_chk(ADDR_RESULT_LOW, k[0] ? tv[7:0] : {tv[1:0], 6'h00});
            rd_chk(ADDR_STATUS, 8'h03);
            wr_reg(ADDR_STATUS, 8'h02);
            rd_chk(ADDR_STATUS, 8'h02);
            $display("test conversion %0d done", k);
        end
        wr_reg(ADDR_CTRL_MAIN, 8'h35);
        repeat (30) @(posedge clk);
        wr_reg(ADDR_CTRL_MAIN, 8'h30);
        @(posedge clk);
        #1 chk(16'(conversion_go_flag_q), 16'h0000);
        chk(16'(conv_done_flag_q), 16'h0000);
        chk(16'(conv_done_irq_enable_q), 16'h0001);
        $display("test power off abort done");
        finish_test();
    end
endmodule
bind adcsq_top adcsq_top_assertions adcsq_top_assertions_i (.clk, .rst, .addr, .wdata, .wr,
    .rd, .rdata_q, .converter_power_on_q, .sample_connect_q, .dac_code_q,
    .conversion_go_flag_q, .conv_done_flag_q);
`default_nettype wire
